// ==== logic/sbl_pkg.sv ====
// constants shared by the secure boot loader files
package sbl_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10; // sys_clk at 100 MHz
  localparam int RESET_DELAY_NS = 15000; // least internal reset time, 15 us
  // least time rounds up to whole cycles
  localparam int RESET_DELAY_CYC = (RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_SECURITY_CONFIG = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LENGTH = 8'h08;
  localparam logic [7:0] REG_CRC = 8'h0c;
  localparam logic [7:0] REG_CONTROL = 8'h10;
  localparam logic [0:0] CTRL_RETRY_BIT = 1'h0; // control bit 0: retry boot

  // ----------------------------------------------------------------
  // security word fields
  // ----------------------------------------------------------------
  localparam int SEC_JTAG_OFF = 0;
  localparam int SEC_LINK_OFF = 1;
  localparam int SEC_SECURE_BOOT = 5;
  localparam int SEC_REDUNDANT = 7;
  localparam int SEC_SECTOR_LOCK_LO = 8;
  localparam int SEC_MASTER_LOCK = 12;
  localparam int SEC_JTAG_OTP_OFF = 13;
  localparam int SEC_USER_LO = 15;
  localparam int SEC_USER_HI = 21;
  localparam int SEC_UID_LO = 22;
  localparam int SEC_UID_HI = 31;
  localparam logic [31:0] SEC_USER_MASK = 32'h003f8000; // bits 21..15
  localparam logic [31:0] SEC_RESET = 32'h0;

  // ----------------------------------------------------------------
  // otp geometry and programming ports
  // ----------------------------------------------------------------
  localparam int OTP_AW = 11; // four sectors of 512 rows
  localparam int OTP_SECTOR_LO = 9; // row bits below the sector number
  localparam logic [10:0] OTP_SEC_WORD_ADDR = 11'h7ff; // where the security word lives
  localparam logic [10:0] OTP_BOOT_ADDR = 11'h0;
  localparam logic [23:0] RES_OTP_ADDR = 24'h100200; // 16-bit address port
  localparam logic [23:0] RES_OTP_DATA = 24'h200100; // 32-bit data port
  localparam logic [23:0] RES_OTP_CTRL = 24'h100300; // 16-bit control port

  // ----------------------------------------------------------------
  // boot image
  // ----------------------------------------------------------------
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_PRESET = 32'hffffffff;
  localparam logic [31:0] CRC_BYPASS = 32'h0d15ab1e;
  localparam int RAM_AW = 15; // 128 KB of 32-bit words
  localparam logic [31:0] RAM_WORDS = 32'h8000;

  // boot sequencer states
  typedef enum logic [3:0] {
    ST_RESET_WAIT = 4'h0,
    ST_SEC_LOAD = 4'h1,
    ST_SEC_WAIT = 4'h2,
    ST_LENGTH = 4'h3,
    ST_PROGRAM = 4'h4,
    ST_CHECK = 4'h5,
    ST_VERIFY = 4'h6,
    ST_RUN = 4'h7,
    ST_ERROR = 4'h8
  } sbl_state_type;

endpackage

// ==== logic/sbl_crc32.sv ====
// byte-wide reflected crc-32 engine
`timescale 1ns/1ps
module sbl_crc32 (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic init, // preset the remainder
  input wire logic en, // fold in one byte
  input wire logic [7:0] data,
  output logic [31:0] crc_q // raw remainder, not yet inverted
);

  logic [31:0] crc_d;
  logic [31:0] stage [0:8]; // remainder after each bit

  // ----------------------------------------------------------------
  // one bit per stage, lsb first as the reflected form needs
  // ----------------------------------------------------------------
  assign stage[0] = crc_q ^ {24'h0, data};
  for (genvar b = 0; b < 8; b++)
  begin : g_bit
    assign stage[b + 1] = stage[b][0] ? ((stage[b] >> 1) ^ sbl_pkg::CRC_POLY) : (stage[b] >> 1); // see RQ11
  end
  assign crc_d = stage[8];

  // ----------------------------------------------------------------
  // remainder register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || init)
    begin
      crc_q <= sbl_pkg::CRC_PRESET; // see RQ11
    end
    else if (en)
    begin
      crc_q <= crc_d;
    end
  end

endmodule

// ==== logic/sbl_boot_loader.sv ====
// secure boot sequencer: security word load, image copy, crc check, otp guard
// Functional notes
// RQ1 - device held in reset while reset low
// RQ2 - gpio pull-downs enabled during reset
// RQ3 - reset held 1 ms after left_io_supply good
// RQ4 - boot starts 15-150 us after release
// RQ5 - security bit 5 boots from otp address 0
// RQ6 - image: length word, program words, check word
// RQ7 - check word 0x0D15AB1E skips crc
// RQ8 - length and check word least byte first
// RQ9 - program copied to ram bottom, started there
// RQ10 - crc covers length and program, not check
// RQ11 - reflected poly, preset ones, result inverted
// RQ12 - security word loaded from otp first
// RQ13 - extra otp content copied and run first
// RQ14 - otp is four sectors of 512 words
// RQ15 - otp programmed via three resource ports
// RQ16 - security bit 0 disables jtag
// RQ17 - security bit 1 blocks link access
// RQ18 - security bit 7 enables redundant rows
// RQ19 - bits 8..11 lock otp sectors 0..3
// RQ20 - bit 12 rejects all otp programming
// RQ21 - bit 13 blocks jtag otp access
// RQ22 - bits 21..15 user, 31..22 user id
// RQ23 - global active-low reset, boot follows
// RQ24 - crc mismatch stops boot, flags error
`timescale 1ns/1ps
module sbl_boot_loader (
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_q,
  // otp read port, data one cycle after the read strobe
  output logic otp_rd_q,
  output logic [10:0] otp_addr_q,
  input wire logic [31:0] otp_rdata,
  // flash byte stream, bytes only while requested
  output logic flash_req_q,
  input wire logic flash_valid,
  input wire logic [7:0] flash_byte,
  // ram write port
  output logic ram_we_q,
  output logic [14:0] ram_addr_q,
  output logic [31:0] ram_wdata_q,
  // processor control
  output logic cpu_reset_q,
  output logic [14:0] cpu_start_addr_q,
  output logic boot_error_q,
  output logic gpio_pulldown_en_q,
  // security features
  output logic jtag_disable_q,
  output logic link_access_block_q,
  output logic otp_redundant_en_q,
  output logic [9:0] jtag_user_id_q,
  input wire logic jtag_otp_req,
  output logic jtag_otp_grant_q,
  // otp programming ports
  input wire logic prog_wr,
  input wire logic [23:0] prog_res_id,
  input wire logic [31:0] prog_wdata,
  output logic otp_pgm_q,
  output logic [15:0] otp_pgm_addr_q,
  output logic [31:0] otp_pgm_data_q,
  output logic otp_pgm_reject_q
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  sbl_pkg::sbl_state_type state_q; // boot sequencer state
  logic [10:0] dly_q; // internal reset timer
  logic [31:0] sec_q; // security configuration word
  logic sec_valid_q; // word has been loaded
  logic from_otp_q; // boot source latched at boot
  logic [10:0] otp_ptr_q; // next otp image word
  logic otp_pend_q; // otp read in flight
  logic sec_pend_q; // in-flight read is the security word
  logic [31:0] obuf_q; // otp word being split into bytes
  logic [2:0] ocnt_q; // bytes left in obuf_q
  logic [1:0] bcnt_q; // byte within the current word
  logic [31:0] len_q; // program length in words
  logic [31:0] left_q; // program words still to copy
  logic [31:0] wbuf_q; // word being assembled
  logic [31:0] chk_q; // stored check word
  logic [14:0] waddr_q; // next ram word
  logic [31:0] crc_raw; // remainder from the engine
  logic byte_ok; // a byte is on offer
  logic [7:0] byte_val; // the byte on offer
  logic parsing; // state consumes image bytes
  logic take; // byte consumed this cycle
  logic crc_en; // byte belongs to crc coverage
  logic crc_init; // preset before a new image
  logic retry; // software asks for a new boot
  logic [31:0] wnext; // word with current byte merged
  logic [15:0] pa_q; // otp address port
  logic [31:0] pd_q; // otp data port
  logic pgm_ok; // programming allowed

  // ----------------------------------------------------------------
  // byte source: otp words split lsb first, or flash stream
  // ----------------------------------------------------------------
  assign parsing = (state_q == sbl_pkg::ST_LENGTH) || (state_q == sbl_pkg::ST_PROGRAM) ||
    (state_q == sbl_pkg::ST_CHECK);
  assign byte_ok = from_otp_q ? (ocnt_q != 3'h0) : flash_valid;
  assign byte_val = from_otp_q ? obuf_q[7:0] : flash_byte;
  assign take = parsing && byte_ok;
  // check word stays outside the crc
  assign crc_en = take && (state_q != sbl_pkg::ST_CHECK); // see RQ10
  assign crc_init = (state_q == sbl_pkg::ST_SEC_WAIT);
  assign retry = reg_wr && (reg_addr == sbl_pkg::REG_CONTROL) &&
    reg_wdata[sbl_pkg::CTRL_RETRY_BIT] && (state_q == sbl_pkg::ST_ERROR);
  // least significant byte first: each lands on top and shifts down
  assign wnext = {byte_val, wbuf_q[31:8]}; // see RQ8

  sbl_crc32 u_crc (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .init(crc_init),
    .en(crc_en),
    .data(byte_val),
    .crc_q(crc_raw)
  );

  // ----------------------------------------------------------------
  // boot sequencer
  // ----------------------------------------------------------------
  // reset is sampled on the clock; the internal reset timer covers
  // the pll relock and runs the shortest allowed delay
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_q <= sbl_pkg::ST_RESET_WAIT; // see RQ1, RQ23
      dly_q <= 11'h0;
    end
    else
    begin
      case (state_q)
        sbl_pkg::ST_RESET_WAIT:
        begin
          // internal reset process before anything else
          if (dly_q == 11'(sbl_pkg::RESET_DELAY_CYC - 1))
          begin
            state_q <= sbl_pkg::ST_SEC_LOAD; // see RQ4
          end
          else
          begin
            dly_q <= dly_q + 11'h1;
          end
        end
        sbl_pkg::ST_SEC_LOAD:
        begin
          state_q <= sbl_pkg::ST_SEC_WAIT; // see RQ12
        end
        sbl_pkg::ST_SEC_WAIT:
        begin
          // security word must be in before the boot source is chosen
          if (sec_pend_q)
          begin
            state_q <= sbl_pkg::ST_LENGTH;
          end
        end
        sbl_pkg::ST_LENGTH:
        begin
          if (take && bcnt_q == 2'h3)
          begin
            // an empty program goes straight to the check word
            if (wnext == 32'h0)
            begin
              state_q <= sbl_pkg::ST_CHECK; // see RQ6
            end
            else if (wnext > sbl_pkg::RAM_WORDS)
            begin
              state_q <= sbl_pkg::ST_ERROR; // image cannot fit in ram
            end
            else
            begin
              state_q <= sbl_pkg::ST_PROGRAM;
            end
          end
        end
        sbl_pkg::ST_PROGRAM:
        begin
          if (take && bcnt_q == 2'h3 && left_q == 32'h1)
          begin
            state_q <= sbl_pkg::ST_CHECK; // see RQ6
          end
        end
        sbl_pkg::ST_CHECK:
        begin
          if (take && bcnt_q == 2'h3)
          begin
            state_q <= sbl_pkg::ST_VERIFY;
          end
        end
        sbl_pkg::ST_VERIFY:
        begin
          if (chk_q == sbl_pkg::CRC_BYPASS || chk_q == ~crc_raw)
          begin
            state_q <= sbl_pkg::ST_RUN; // see RQ7, RQ11
          end
          else
          begin
            state_q <= sbl_pkg::ST_ERROR; // see RQ24
          end
        end
        sbl_pkg::ST_RUN:
        begin
          state_q <= sbl_pkg::ST_RUN; // program runs until the next chip reset
        end
        sbl_pkg::ST_ERROR:
        begin
          if (retry)
          begin
            state_q <= sbl_pkg::ST_SEC_LOAD;
          end
        end
        default:
        begin
          state_q <= sbl_pkg::ST_RESET_WAIT;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // otp reads: security word first, then image words on demand
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      otp_rd_q <= 1'b0;
      otp_addr_q <= 11'h0;
      otp_ptr_q <= sbl_pkg::OTP_BOOT_ADDR;
      otp_pend_q <= 1'b0;
      sec_pend_q <= 1'b0;
      obuf_q <= 32'h0;
      ocnt_q <= 3'h0;
    end
    else
    begin
      otp_rd_q <= 1'b0;
      otp_pend_q <= otp_rd_q;
      sec_pend_q <= 1'b0;
      if (state_q == sbl_pkg::ST_SEC_LOAD)
      begin
        otp_rd_q <= 1'b1;
        otp_addr_q <= sbl_pkg::OTP_SEC_WORD_ADDR; // see RQ12
        otp_ptr_q <= sbl_pkg::OTP_BOOT_ADDR; // image starts at row 0 // see RQ5, RQ13
        ocnt_q <= 3'h0;
      end
      else if (state_q == sbl_pkg::ST_SEC_WAIT)
      begin
        sec_pend_q <= otp_rd_q;
      end
      else if (otp_pend_q)
      begin
        obuf_q <= otp_rdata;
        ocnt_q <= 3'h4;
      end
      else if (take)
      begin
        obuf_q <= {8'h00, obuf_q[31:8]};
        ocnt_q <= ocnt_q - 3'h1;
      end
      else if (from_otp_q && parsing && ocnt_q == 3'h0 && !otp_rd_q)
      begin
        // fetch only when the buffer is dry, so at most one read is in flight
        otp_rd_q <= 1'b1;
        otp_addr_q <= otp_ptr_q;
        otp_ptr_q <= otp_ptr_q + 11'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // security word and the features it drives
  // ----------------------------------------------------------------
  // until the word is loaded every feature sits in its locked state
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sec_q <= sbl_pkg::SEC_RESET;
      sec_valid_q <= 1'b0;
      from_otp_q <= 1'b0;
    end
    else if (sec_pend_q)
    begin
      sec_q <= otp_rdata; // see RQ12
      sec_valid_q <= 1'b1;
      from_otp_q <= otp_rdata[sbl_pkg::SEC_SECURE_BOOT]; // see RQ5
    end
    else if (reg_wr && reg_addr == sbl_pkg::REG_SECURITY_CONFIG)
    begin
      // only the end-user field is writable by software
      sec_q <= (sec_q & ~sbl_pkg::SEC_USER_MASK) | (reg_wdata & sbl_pkg::SEC_USER_MASK); // see RQ22
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      jtag_disable_q <= 1'b1;
      link_access_block_q <= 1'b1;
      otp_redundant_en_q <= 1'b0;
      jtag_user_id_q <= 10'h0;
      jtag_otp_grant_q <= 1'b0;
    end
    else
    begin
      jtag_disable_q <= !sec_valid_q || sec_q[sbl_pkg::SEC_JTAG_OFF]; // see RQ16
      link_access_block_q <= !sec_valid_q || sec_q[sbl_pkg::SEC_LINK_OFF]; // see RQ17
      otp_redundant_en_q <= sec_valid_q && sec_q[sbl_pkg::SEC_REDUNDANT]; // see RQ18
      jtag_user_id_q <= sec_q[sbl_pkg::SEC_UID_HI:sbl_pkg::SEC_UID_LO]; // see RQ22
      // jtag otp reads and writes both need this grant
      jtag_otp_grant_q <= jtag_otp_req && sec_valid_q &&
        !sec_q[sbl_pkg::SEC_JTAG_OTP_OFF]; // see RQ21
    end
  end

  // ----------------------------------------------------------------
  // otp programming ports and lock checks
  // ----------------------------------------------------------------
  // sector number sits above the 512 rows of each sector
  assign pgm_ok = sec_valid_q && !sec_q[sbl_pkg::SEC_MASTER_LOCK] && // see RQ20
    !sec_q[sbl_pkg::SEC_SECTOR_LOCK_LO + int'(pa_q[10:9])]; // see RQ14, RQ19

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pa_q <= 16'h0;
      pd_q <= 32'h0;
      otp_pgm_q <= 1'b0;
      otp_pgm_addr_q <= 16'h0;
      otp_pgm_data_q <= 32'h0;
      otp_pgm_reject_q <= 1'b0;
    end
    else
    begin
      otp_pgm_q <= 1'b0;
      otp_pgm_reject_q <= 1'b0;
      if (prog_wr && prog_res_id == sbl_pkg::RES_OTP_ADDR)
      begin
        pa_q <= prog_wdata[15:0]; // see RQ15
      end
      else if (prog_wr && prog_res_id == sbl_pkg::RES_OTP_DATA)
      begin
        pd_q <= prog_wdata; // see RQ15
      end
      else if (prog_wr && prog_res_id == sbl_pkg::RES_OTP_CTRL && prog_wdata[0])
      begin
        // control bit 0 starts one word program, or is refused
        otp_pgm_q <= pgm_ok; // see RQ15
        otp_pgm_reject_q <= !pgm_ok; // see RQ19, RQ20
        otp_pgm_addr_q <= pa_q;
        otp_pgm_data_q <= pd_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // image parsing: length, program copy, check word
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || state_q == sbl_pkg::ST_SEC_LOAD)
    begin
      bcnt_q <= 2'h0;
      len_q <= 32'h0;
      left_q <= 32'h0;
      wbuf_q <= 32'h0;
      chk_q <= 32'h0;
      waddr_q <= 15'h0; // see RQ9
    end
    else if (take)
    begin
      bcnt_q <= bcnt_q + 2'h1;
      wbuf_q <= wnext; // see RQ8
      if (bcnt_q == 2'h3)
      begin
        if (state_q == sbl_pkg::ST_LENGTH)
        begin
          len_q <= wnext; // see RQ6
          left_q <= wnext;
        end
        else if (state_q == sbl_pkg::ST_PROGRAM)
        begin
          left_q <= left_q - 32'h1;
          waddr_q <= waddr_q + 15'h1; // see RQ9
        end
        else
        begin
          chk_q <= wnext; // see RQ7
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // ram writes and flash request
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ram_we_q <= 1'b0;
      ram_addr_q <= 15'h0;
      ram_wdata_q <= 32'h0;
      flash_req_q <= 1'b0;
    end
    else
    begin
      ram_we_q <= take && bcnt_q == 2'h3 && state_q == sbl_pkg::ST_PROGRAM;
      if (take && bcnt_q == 2'h3 && state_q == sbl_pkg::ST_PROGRAM)
      begin
        ram_addr_q <= waddr_q; // see RQ9
        ram_wdata_q <= wnext;
      end
      // the flash may only send while this stands; it drops on the same edge that takes the last check byte
      flash_req_q <= !from_otp_q && parsing &&
        !(take && state_q == sbl_pkg::ST_CHECK && bcnt_q == 2'h3);
    end
  end

  // ----------------------------------------------------------------
  // processor control and reset-time pin state
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cpu_reset_q <= 1'b1; // see RQ1
      cpu_start_addr_q <= 15'h0;
      boot_error_q <= 1'b0;
      gpio_pulldown_en_q <= 1'b1; // see RQ2
    end
    else
    begin
      gpio_pulldown_en_q <= 1'b0;
      cpu_start_addr_q <= 15'h0; // execution starts where the copy began // see RQ9
      cpu_reset_q <= (state_q != sbl_pkg::ST_RUN); // see RQ24
      boot_error_q <= (state_q == sbl_pkg::ST_ERROR); // see RQ24
    end
  end

  // ----------------------------------------------------------------
  // register read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      reg_rdata_q <= 32'h0;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        sbl_pkg::REG_SECURITY_CONFIG: reg_rdata_q <= sec_q;
        sbl_pkg::REG_STATUS: reg_rdata_q <= {25'h0, from_otp_q, sec_valid_q, state_q,
          (state_q == sbl_pkg::ST_ERROR)};
        sbl_pkg::REG_LENGTH: reg_rdata_q <= len_q;
        sbl_pkg::REG_CRC: reg_rdata_q <= ~crc_raw;
        default: reg_rdata_q <= 32'h0; // unmapped and write-only read zero
      endcase
    end
    else
    begin
      reg_rdata_q <= 32'h0;
    end
  end

endmodule

// ==== dv/sbl_boot_loader_asserts.sv ====
// port checker for the boot loader
`timescale 1ns/1ps
module sbl_checker (
  input logic sys_clk,
  input logic rst_n,
  input logic otp_rd_q,
  input logic [10:0] otp_addr_q,
  input logic flash_req_q,
  input logic ram_we_q,
  input logic [14:0] ram_addr_q,
  input logic cpu_reset_q,
  input logic [14:0] cpu_start_addr_q,
  input logic boot_error_q,
  input logic gpio_pulldown_en_q,
  input logic jtag_otp_req,
  input logic jtag_otp_grant_q,
  input logic prog_wr,
  input logic [23:0] prog_res_id,
  input logic otp_pgm_q,
  input logic otp_pgm_reject_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic seen_q; // security word fetched
  logic [14:0] cnt_q; // cycles since release, saturating
  logic [14:0] wcnt_q; // ram words written
  always_ff @(posedge sys_clk) seen_q <= rst_n && (seen_q || (otp_rd_q && otp_addr_q == 11'h7ff));
  always_ff @(posedge sys_clk) cnt_q <= !rst_n ? 15'h0 : cnt_q + {14'h0, cnt_q != 15'h7fff};
  always_ff @(posedge sys_clk) wcnt_q <= !rst_n ? 15'h0 : wcnt_q + {14'h0, ram_we_q};
  // reset checks run during reset
  property p_hold;
    disable iff (1'b0) !rst_n |=> cpu_reset_q && gpio_pulldown_en_q && !ram_we_q;
  endproperty
  a_hold: assert property (p_hold) else $error("core not held in reset");
  property p_pull;
    rst_n |=> !gpio_pulldown_en_q;
  endproperty
  a_pull: assert property (p_pull) else $error("pull-downs stay on");
  property p_early;
    otp_rd_q |-> cnt_q >= 15'h5db;
  endproperty
  a_early: assert property (p_early) else $error("boot began too early");
  property p_late;
    cnt_q == 15'h3a98 |-> seen_q;
  endproperty
  a_late: assert property (p_late) else $error("boot began too late");
  property p_first;
    flash_req_q |-> seen_q;
  endproperty
  a_first: assert property (p_first) else $error("image read before word");
  property p_addr;
    ram_we_q |-> ram_addr_q == wcnt_q;
  endproperty
  a_addr: assert property (p_addr) else $error("ram address out of order");
  property p_start;
    $fell(cpu_reset_q) |-> cpu_start_addr_q == 15'h0 && !boot_error_q && !flash_req_q;
  endproperty
  a_start: assert property (p_start) else $error("bad core start");
  property p_err;
    boot_error_q |-> cpu_reset_q;
  endproperty
  a_err: assert property (p_err) else $error("core runs after error");
  property p_grant;
    jtag_otp_grant_q |-> $past(jtag_otp_req) && seen_q;
  endproperty
  a_grant: assert property (p_grant) else $error("stray otp grant");
  property p_pgm;
    otp_pgm_q || otp_pgm_reject_q |->
      !(otp_pgm_q && otp_pgm_reject_q) && $past(prog_wr && prog_res_id == 24'h100300);
  endproperty
  a_pgm: assert property (p_pgm) else $error("bad program answer");
  c_run: cover property ($fell(cpu_reset_q));
  c_err: cover property ($rose(boot_error_q));
  c_rej: cover property (otp_pgm_reject_q);
endmodule
bind sbl_boot_loader sbl_checker u_chk (.*);

// ==== dv/sbl_flash_model.sv ====
// flash model streaming a boot image one byte at a time
`timescale 1ns/1ps
module sbl_flash_model (
  input logic sys_clk,
  input logic flash_req_q,
  output logic flash_valid = 1'b0,
  output logic [7:0] flash_byte = 8'h00
);
  logic [7:0] img[$]; // image bytes in wire order, filled by the bench
  logic v;
  // random stalls; junk data when no byte is offered
  always @(posedge sys_clk)
  begin
    if (flash_valid && flash_req_q)
      void'(img.pop_front());
    v = flash_req_q && img.size() > 0 && $urandom_range(3) != 0;
    flash_valid <= v;
    flash_byte <= v ? img[0] : ~flash_byte;
  end
endmodule

// ==== dv/test_secure_boot_loader.sv ====
// self-checking bench for the secure boot loader
`timescale 1ns/1ps
module test_secure_boot_loader;
  logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, prog_wr = 0;
  logic jtag_otp_req = 0, otp_rd_q, flash_req_q, flash_valid, ram_we_q, cpu_reset_q;
  logic boot_error_q, gpio_pulldown_en_q, jtag_disable_q, link_access_block_q;
  logic otp_redundant_en_q, jtag_otp_grant_q, otp_pgm_q, otp_pgm_reject_q;
  logic [7:0] reg_addr = 8'h00, flash_byte;
  logic [31:0] reg_wdata = 32'h0, otp_rdata = 32'h0, prog_wdata = 32'h0;
  logic [31:0] reg_rdata_q, ram_wdata_q, otp_pgm_data_q, sec, rdv;
  logic [23:0] prog_res_id = 24'h0;
  logic [14:0] ram_addr_q, cpu_start_addr_q;
  logic [10:0] otp_addr_q;
  logic [9:0] jtag_user_id_q;
  logic [15:0] otp_pgm_addr_q;
  logic [31:0] exp_words[$]; // expected ram words
  int error_cnt = 0, total_checks = 0, widx = 0, cyc = 0;
  sbl_boot_loader u_dut (.*);
  sbl_flash_model u_flash (.*);
  always #5 sys_clk = ~sys_clk;
  // otp answers one cycle after each read strobe, junk otherwise
  always @(posedge sys_clk)
    otp_rdata <= otp_rd_q ? (otp_addr_q == 11'h7ff ? sec : 32'h0) : ~otp_rdata;
  // every ram write must carry the next program word
  always @(posedge sys_clk)
    if (ram_we_q === 1'b1)
    begin
      chk(ram_wdata_q, exp_words[widx], "ram word");
      widx++;
    end
  // hang guard, well above three boots
  always @(posedge sys_clk)
    if (++cyc == 20000)
    begin
      error_cnt++;
      complete_run;
    end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // reflected crc, preset ones, result inverted
  function automatic logic [31:0] crc(input logic [7:0] q[$]);
    logic [31:0] c;
    c = 32'hffffffff;
    foreach (q[i])
    begin
      c = c ^ {24'h0, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    end
    return ~c;
  endfunction
  // words travel least significant byte first
  function automatic void put(ref logic [7:0] q[$], input logic [31:0] w);
    for (int k = 0; k < 4; k++)
      q.push_back(w[8*k+:8]);
  endfunction
  task automatic rd(input logic [7:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rdv = reg_rdata_q;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // address, data, then start
  task automatic pg(input logic [15:0] a, input logic [31:0] d, input logic rej);
    prog_wr <= 1'b1;
    prog_res_id <= 24'h100200;
    prog_wdata <= {16'h0, a};
    @(posedge sys_clk);
    prog_res_id <= 24'h200100;
    prog_wdata <= d;
    @(posedge sys_clk);
    prog_res_id <= 24'h100300;
    prog_wdata <= 32'h1;
    @(posedge sys_clk);
    prog_wr <= 1'b0;
    #1 chk(otp_pgm_reject_q, rej, "reject");
    chk(otp_pgm_q, !rej, "program");
    chk(otp_pgm_addr_q, a, "pgm addr");
    chk(otp_pgm_data_q, d, "pgm data");
  endtask
  // mode 0 good crc, 1 bad crc, 2 bypass
  task automatic boot(input logic [31:0] s, input int n, input int mode);
    logic [7:0] b[$];
    logic [31:0] w;
    rst_n <= 1'b0;
    sec = s;
    exp_words.delete();
    put(b, n);
    for (int i = 0; i < n; i++)
    begin
      w = $urandom;
      exp_words.push_back(w);
      put(b, w);
    end
    w = mode == 2 ? 32'h0d15ab1e : crc(b) ^ {31'h0, mode == 1};
    put(b, w);
    u_flash.img = b;
    repeat (12) @(posedge sys_clk);
    widx = 0;
    rst_n <= 1'b1;
    for (int i = 0; i < 3000 && cpu_reset_q === 1'b1 && boot_error_q !== 1'b1; i++)
      @(posedge sys_clk);
    #1 chk(boot_error_q, mode == 1, "boot error");
    chk(cpu_reset_q, mode == 1, "core reset");
    chk(widx, n, "word count");
  endtask
  initial
  begin
    void'($urandom(98));
    boot(($urandom & 32'hffffeedf) | 32'h200, $urandom_range(4, 1), 0);
    chk(jtag_disable_q, sec[0], "jtag off");
    chk(link_access_block_q, sec[1], "link block");
    chk(otp_redundant_en_q, sec[7], "redundant");
    chk(jtag_user_id_q, sec[31:22], "user id");
    rd(8'h00);
    chk(rdv, sec, "security");
    wr(8'h00, 32'hffffffff);
    rd(8'h00);
    chk(rdv, sec | 32'h003f8000, "user bits");
    rd(8'h40);
    chk(rdv, 32'h0, "unmapped");
    pg(16'h0200, $urandom, 1'b1);
    pg(16'h0010, $urandom, 1'b0);
    jtag_otp_req <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chk(jtag_otp_grant_q, !sec[13], "jtag otp");
    jtag_otp_req <= 1'b0;
    boot(sec | 32'h1000, 2, 1);
    pg(16'h0010, 32'h1, 1'b1);
    boot(sec, 0, 2);
    complete_run;
  end
endmodule
